/* hw/csp_pkg.sv */
// Constants shared by the 144-bit cascaded search pipeline
package csp_pkg;
   localparam int          KEY_W          = 72;
   localparam int          CMD_W          = 11;
   localparam int          ADDR_W         = 24;
   localparam int          LOC_COUNT      = 16;
   localparam int          LOC_W          = 4;
   localparam int          PAIR_COUNT     = 8;
   localparam int          GMASK_COUNT    = 32;
   localparam int          GMASK_IDX_W    = 5;
   localparam int          CMP_PAIR_COUNT = 16;
   localparam int          SSR_COUNT      = 8;
   localparam int          STAGES         = 5;
   localparam int          FLAG_DELAY_MAX = 7;
   localparam logic [1:0]  OP_SEARCH      = 2'h2;
   localparam logic [1:0]  TABLE_SIZE_CODE_SINGLE    = 2'h0;
   localparam logic [1:0]  TABLE_SIZE_CODE_BLOCK     = 2'h1;
   localparam int          CMD_OP_LSB     = 0;
   localparam int          CMD_CYCLE_A_BIT = 2;
   localparam int          CMD_HI_BIT     = 10;
   localparam int          CMD_IDX_LSB    = 3;
   localparam int          CMD_TAG_LSB    = 6;
   localparam int          CMD_CMP_LSB    = 2;
   localparam int          SRAM_ADDRESS_OUT_TAG_LSB   = 21;
   localparam int          AGE_LHO        = 3;
   localparam int          AGE_LOCAL      = 4;
   localparam int          AGE_BLOCK      = 5;
   localparam logic [ADDR_W-1:0] SRAM_ADDRESS_OUT_RESET = 24'h000000;
   typedef enum logic [1:0] {
      CSP_IDLE   = 2'b01,
      CSP_SECOND = 2'b10
   } csp_state_type;
endpackage : csp_pkg

/* hw/csp_delay_line.sv */
// Shift register with every tap brought out
`timescale 1ns/100ps
`default_nettype none
module csp_delay_line #(
   parameter int W = 3,
   parameter int D = 7
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Data
   input  wire logic [W-1:0]   din,
   output logic      [D*W-1:0] taps
);
   logic [D*W-1:0] taps_next;

   always_comb begin
      taps_next = {taps[(D-1)*W-1:0], din};
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         taps <= '0;
      end else begin
         taps <= taps_next;
      end
   end
endmodule : csp_delay_line
`default_nettype wire

/* hw/csp_search.sv */
// Search-command path of one cascadable 144-bit search device
//
// Overview of operation
// - Cycle A bits 8:6 are copied to sram_address_out 23:21 on a win.
// - Cycle A data is the upper key half, compared with even locations.
// - Cycle B bits 8:6 pick the result register for address and hit flag.
// - Cycle B data is the lower key half, compared with odd locations.
// - Even global mask masks cycle A word, odd mask masks cycle B word.
// - Key halves stored in comparand pair; store op writes even and odd in the same cycle.
// - Only the first non-full device may run a comparand store op.
// - Lowest matching location, using local masks, is the reported address.
// - A 144-bit hit address is always even.
// - Only the global winner drives outputs; default drivers cover misses.
// - Searches take two clocks and may run back to back.
// - Single device: SRAM outputs appear 4 cycles after the command.
// - Latency is 5 cycles for up to eight devices, 6 for up to 31.
// - Flags lag the SRAM address by flag_delay_code cycles, 0 to 7.
// - Hit output bits all equal; hit inputs are ORed together.
// - Own result at 4 cycles, block arbitration at 5, global at 6.
// - Store op supported in only one block of a deep cascade.
`timescale 1ns/100ps
`default_nettype none
module csp_search (
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   // Command and compare buses
   input  wire logic        COMMAND_VALID,
   input  wire logic [10:0] COMMAND_BUS,
   input  wire logic [71:0] COMPARE_DATA_BUS,
   // Configuration
   input  wire logic [1:0]  TABLE_SIZE_CODE,
   input  wire logic [2:0]  FLAG_DELAY_CODE,
   input  wire logic        SRAM_DEFAULT_DRIVER,
   input  wire logic        FLAG_DEFAULT_DRIVER,
   input  wire logic        FIRST_NONFULL_DEVICE,
   input  wire logic        STORE_BLOCK_ENABLE,
   // Table, mask and store loading
   input  wire logic        TABLE_WR_EN,
   input  wire logic [3:0]  TABLE_WR_LOC,
   input  wire logic [71:0] TABLE_WR_DATA,
   input  wire logic [71:0] TABLE_WR_MASK,
   input  wire logic        GMASK_WR_EN,
   input  wire logic [4:0]  GMASK_WR_INDEX,
   input  wire logic [71:0] GMASK_WR_DATA,
   input  wire logic        STORE_OP,
   input  wire logic [3:0]  STORE_CMP_INDEX,
   input  wire logic [2:0]  STORE_PAIR,
   input  wire logic [2:0]  SSR_READ_INDEX,
   // Cascade hit lines
   input  wire logic [6:0]  LOCAL_HIT_IN,
   input  wire logic [2:0]  BLOCK_HIT_IN,
   output logic      [1:0]  LOCAL_HIT_OUT,
   output logic      [2:0]  BLOCK_HIT_OUT,
   // SRAM and flag outputs
   output logic      [23:0] SRAM_ADDRESS_OUT,
   output logic             SRAM_OE_N,
   output logic             SRAM_CHIP_ENABLE_N,
   output logic             SRAM_LATCH_ENABLE_N,
   output logic             SRAM_WRITE_ENABLE_N,
   output logic             SEARCH_SUCCESS_FLAG,
   output logic             SEARCH_RESULT_VALID,
   output logic             FLAG_OE_N,
   // Status
   output logic      [24:0] SSR_READ_DATA,
   output logic             TABLE_FULL
);
   localparam int KW = csp_pkg::KEY_W;
   localparam int AW = csp_pkg::ADDR_W;
   localparam int FD = csp_pkg::FLAG_DELAY_MAX;

   // Command capture, table and register storage
   csp_pkg::csp_state_type state_reg, state_next;
   logic [KW-1:0] key_a_reg, key_a_next;
   logic [KW-1:0] gm_odd_reg, gm_odd_next;
   logic [2:0]    tag_reg, tag_next;
   logic [KW-1:0] tbl_data_reg [csp_pkg::LOC_COUNT];
   logic [KW-1:0] tbl_data_next [csp_pkg::LOC_COUNT];
   logic [KW-1:0] tbl_mask_reg [csp_pkg::LOC_COUNT];
   logic [KW-1:0] tbl_mask_next [csp_pkg::LOC_COUNT];
   logic [csp_pkg::LOC_COUNT-1:0] tbl_valid_reg, tbl_valid_next;
   logic [KW-1:0] gmask_reg [csp_pkg::GMASK_COUNT];
   logic [KW-1:0] gmask_next [csp_pkg::GMASK_COUNT];
   logic [KW-1:0] cmp_even_reg [csp_pkg::CMP_PAIR_COUNT];
   logic [KW-1:0] cmp_even_next [csp_pkg::CMP_PAIR_COUNT];
   logic [KW-1:0] cmp_odd_reg [csp_pkg::CMP_PAIR_COUNT];
   logic [KW-1:0] cmp_odd_next [csp_pkg::CMP_PAIR_COUNT];
   logic          launch;
   logic          match_hit;
   logic [AW-1:0] match_addr;
   logic [4:0]    gm_idx;
   logic [KW-1:0] key_b;

   always_comb begin
      state_next = state_reg;
      key_a_next = key_a_reg;
      gm_odd_next = gm_odd_reg;
      tag_next = tag_reg;
      tbl_data_next = tbl_data_reg;
      tbl_mask_next = tbl_mask_reg;
      tbl_valid_next = tbl_valid_reg;
      gmask_next = gmask_reg;
      cmp_even_next = cmp_even_reg;
      cmp_odd_next = cmp_odd_reg;
      launch = 1'b0;
      gm_idx = {COMMAND_BUS[csp_pkg::CMD_HI_BIT],
                COMMAND_BUS[csp_pkg::CMD_IDX_LSB +: 3], 1'b0};
      key_b = COMPARE_DATA_BUS & gm_odd_reg;
      case (state_reg)
         csp_pkg::CSP_IDLE: begin
            if (COMMAND_VALID &&
                COMMAND_BUS[csp_pkg::CMD_OP_LSB +: 2] == csp_pkg::OP_SEARCH &&
                !COMMAND_BUS[csp_pkg::CMD_CYCLE_A_BIT]) begin
               key_a_next = COMPARE_DATA_BUS & gmask_reg[gm_idx];
               gm_odd_next = gmask_reg[gm_idx | 5'h01];
               tag_next = COMMAND_BUS[csp_pkg::CMD_TAG_LSB +: 3];
               state_next = csp_pkg::CSP_SECOND;
            end
         end
         csp_pkg::CSP_SECOND: begin
            state_next = csp_pkg::CSP_IDLE;
            if (COMMAND_VALID &&
                COMMAND_BUS[csp_pkg::CMD_OP_LSB +: 2] == csp_pkg::OP_SEARCH)
            begin
               launch = 1'b1;
               cmp_even_next[COMMAND_BUS[csp_pkg::CMD_CMP_LSB +: 4]] =
                  key_a_reg;
               cmp_odd_next[COMMAND_BUS[csp_pkg::CMD_CMP_LSB +: 4]] =
                  key_b;
            end
         end
         default: state_next = csp_pkg::CSP_IDLE;
      endcase
      if (TABLE_WR_EN) begin
         tbl_data_next[TABLE_WR_LOC] = TABLE_WR_DATA;
         tbl_mask_next[TABLE_WR_LOC] = TABLE_WR_MASK;
         tbl_valid_next[TABLE_WR_LOC] = 1'b1;
      end
      if (GMASK_WR_EN) begin
         gmask_next[GMASK_WR_INDEX] = GMASK_WR_DATA;
      end
      if (STORE_OP && FIRST_NONFULL_DEVICE && STORE_BLOCK_ENABLE) begin
         tbl_data_next[{STORE_PAIR, 1'b0}] = cmp_even_reg[STORE_CMP_INDEX];
         tbl_data_next[{STORE_PAIR, 1'b1}] = cmp_odd_reg[STORE_CMP_INDEX];
         tbl_mask_next[{STORE_PAIR, 1'b0}] = '1;
         tbl_mask_next[{STORE_PAIR, 1'b1}] = '1;
         tbl_valid_next[{STORE_PAIR, 1'b0}] = 1'b1;
         tbl_valid_next[{STORE_PAIR, 1'b1}] = 1'b1;
      end
   end

   // Masked compare of every entry pair, lowest pair wins
   always_comb begin
      match_hit = 1'b0;
      match_addr = '0;
      for (int p = csp_pkg::PAIR_COUNT - 1; p >= 0; p--) begin
         if (tbl_valid_reg[2*p] && tbl_valid_reg[2*p+1] &&
             ((key_a_reg ^ tbl_data_reg[2*p]) & tbl_mask_reg[2*p]) == '0 &&
             ((key_b ^ tbl_data_reg[2*p+1]) & tbl_mask_reg[2*p+1]) == '0)
         begin
            match_hit = 1'b1;
            match_addr = {tag_reg, 17'h00000,
                          3'(p), 1'b0};
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         state_reg <= csp_pkg::CSP_IDLE;
         key_a_reg <= '0;
         gm_odd_reg <= '0;
         tag_reg <= '0;
         tbl_valid_reg <= '0;
         for (int i = 0; i < csp_pkg::LOC_COUNT; i++) begin
            tbl_data_reg[i] <= '0;
            tbl_mask_reg[i] <= '0;
         end
         for (int i = 0; i < csp_pkg::GMASK_COUNT; i++) begin
            gmask_reg[i] <= '0;
         end
         for (int i = 0; i < csp_pkg::CMP_PAIR_COUNT; i++) begin
            cmp_even_reg[i] <= '0;
            cmp_odd_reg[i] <= '0;
         end
      end else begin
         state_reg <= state_next;
         key_a_reg <= key_a_next;
         gm_odd_reg <= gm_odd_next;
         tag_reg <= tag_next;
         tbl_valid_reg <= tbl_valid_next;
         tbl_data_reg <= tbl_data_next;
         tbl_mask_reg <= tbl_mask_next;
         gmask_reg <= gmask_next;
         cmp_even_reg <= cmp_even_next;
         cmp_odd_reg <= cmp_odd_next;
      end
   end

   // Result pipeline, cascade arbitration and outputs
   logic [csp_pkg::STAGES:1] st_valid_reg, st_valid_next;
   logic [csp_pkg::STAGES:1] st_hit_reg, st_hit_next;
   logic [csp_pkg::STAGES:1] st_any_reg, st_any_next;
   logic [AW-1:0] st_addr_reg [1:csp_pkg::STAGES];
   logic [AW-1:0] st_addr_next [1:csp_pkg::STAGES];
   logic [2:0]    st_ssr_reg [1:csp_pkg::STAGES];
   logic [2:0]    st_ssr_next [1:csp_pkg::STAGES];
   logic [24:0]   ssr_reg [csp_pkg::SSR_COUNT];
   logic [24:0]   ssr_next [csp_pkg::SSR_COUNT];
   logic          lhi_any, bhi_any;
   logic          dec_valid, dec_win, dec_miss;
   logic [AW-1:0] dec_addr;
   logic [2:0]    dec_ssr;
   logic          drv_sram, drv_flag;
   logic [2:0]    flag_in;
   logic [FD*3-1:0] flag_taps;
   logic [2:0]    flag_sel;
   logic [23:0]   sram_address_out_next;
   logic          sram_oe_n_next, ce_n_next;
   logic [1:0]    lho_next;
   logic [2:0]    bho_next;

   always_comb begin
      lhi_any = |LOCAL_HIT_IN;
      bhi_any = |BLOCK_HIT_IN;
      st_valid_next = {st_valid_reg[csp_pkg::STAGES-1:1], launch};
      st_hit_next = {st_hit_reg[csp_pkg::STAGES-1:1], launch & match_hit};
      st_any_next = st_any_reg;
      st_addr_next[1] = match_addr;
      st_ssr_next[1] = COMMAND_BUS[csp_pkg::CMD_TAG_LSB +: 3];
      for (int k = 2; k <= csp_pkg::STAGES; k++) begin
         st_addr_next[k] = st_addr_reg[k-1];
         st_ssr_next[k] = st_ssr_reg[k-1];
      end
      // Block-local arbitration while the own result sits at age 4
      st_hit_next[csp_pkg::AGE_BLOCK] =
         st_hit_reg[csp_pkg::AGE_LOCAL] & ~lhi_any;
      st_any_next[csp_pkg::AGE_BLOCK] =
         st_hit_reg[csp_pkg::AGE_LOCAL] | lhi_any;
      lho_next = {2{st_hit_reg[csp_pkg::AGE_LHO]}};
      bho_next = {3{st_hit_next[csp_pkg::AGE_BLOCK]}};
      // Decision one cycle before the result cycle
      if (TABLE_SIZE_CODE == csp_pkg::TABLE_SIZE_CODE_SINGLE) begin
         dec_valid = st_valid_reg[csp_pkg::AGE_LHO];
         dec_win = st_hit_reg[csp_pkg::AGE_LHO];
         dec_miss = ~st_hit_reg[csp_pkg::AGE_LHO];
         dec_addr = st_addr_reg[csp_pkg::AGE_LHO];
         dec_ssr = st_ssr_reg[csp_pkg::AGE_LHO];
      end else if (TABLE_SIZE_CODE == csp_pkg::TABLE_SIZE_CODE_BLOCK) begin
         dec_valid = st_valid_reg[csp_pkg::AGE_LOCAL];
         dec_win = st_hit_reg[csp_pkg::AGE_LOCAL] & ~lhi_any;
         dec_miss = ~st_hit_reg[csp_pkg::AGE_LOCAL] & ~lhi_any;
         dec_addr = st_addr_reg[csp_pkg::AGE_LOCAL];
         dec_ssr = st_ssr_reg[csp_pkg::AGE_LOCAL];
      end else begin
         dec_valid = st_valid_reg[csp_pkg::AGE_BLOCK];
         dec_win = st_hit_reg[csp_pkg::AGE_BLOCK] & ~bhi_any;
         dec_miss = ~st_any_reg[csp_pkg::AGE_BLOCK] & ~bhi_any;
         dec_addr = st_addr_reg[csp_pkg::AGE_BLOCK];
         dec_ssr = st_ssr_reg[csp_pkg::AGE_BLOCK];
      end
      drv_sram = dec_valid & (dec_win | (dec_miss & SRAM_DEFAULT_DRIVER));
      drv_flag = dec_valid & (dec_win | (dec_miss & FLAG_DEFAULT_DRIVER));
      sram_address_out_next = dec_win ? dec_addr : csp_pkg::SRAM_ADDRESS_OUT_RESET;
      sram_oe_n_next = ~drv_sram;
      ce_n_next = ~(drv_sram & dec_win);
      flag_in = {drv_flag, drv_flag & dec_win, drv_flag};
      ssr_next = ssr_reg;
      if (dec_valid && (dec_win || dec_miss)) begin
         ssr_next[dec_ssr] = {dec_win, dec_addr};
      end
      flag_sel = (FLAG_DELAY_CODE == 3'h0) ? flag_in
               : flag_taps[(32'(FLAG_DELAY_CODE) - 1) * 3 +: 3];
   end

   csp_delay_line #(.W(3), .D(FD)) csp_delay_line_inst (
      .clk   (CORE_CLK),
      .rst_b (RST_B),
      .din   (flag_in),
      .taps  (flag_taps)
   );

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         st_valid_reg <= '0;
         st_hit_reg <= '0;
         st_any_reg <= '0;
         for (int k = 1; k <= csp_pkg::STAGES; k++) begin
            st_addr_reg[k] <= '0;
            st_ssr_reg[k] <= '0;
         end
         for (int i = 0; i < csp_pkg::SSR_COUNT; i++) begin
            ssr_reg[i] <= '0;
         end
         LOCAL_HIT_OUT <= '0;
         BLOCK_HIT_OUT <= '0;
         SRAM_ADDRESS_OUT <= csp_pkg::SRAM_ADDRESS_OUT_RESET;
         SRAM_OE_N <= 1'b1;
         SRAM_CHIP_ENABLE_N <= 1'b1;
         SRAM_LATCH_ENABLE_N <= 1'b1;
         SRAM_WRITE_ENABLE_N <= 1'b1;
         SEARCH_SUCCESS_FLAG <= 1'b0;
         SEARCH_RESULT_VALID <= 1'b0;
         FLAG_OE_N <= 1'b1;
         SSR_READ_DATA <= '0;
         TABLE_FULL <= 1'b0;
      end else begin
         st_valid_reg <= st_valid_next;
         st_hit_reg <= st_hit_next;
         st_any_reg <= st_any_next;
         st_addr_reg <= st_addr_next;
         st_ssr_reg <= st_ssr_next;
         ssr_reg <= ssr_next;
         LOCAL_HIT_OUT <= lho_next;
         BLOCK_HIT_OUT <= bho_next;
         SRAM_ADDRESS_OUT <= sram_address_out_next;
         SRAM_OE_N <= sram_oe_n_next;
         SRAM_CHIP_ENABLE_N <= ce_n_next;
         SRAM_LATCH_ENABLE_N <= ce_n_next;
         SRAM_WRITE_ENABLE_N <= 1'b1;
         FLAG_OE_N <= ~flag_sel[2];
         SEARCH_SUCCESS_FLAG <= flag_sel[1];
         SEARCH_RESULT_VALID <= flag_sel[0];
         SSR_READ_DATA <= ssr_reg[SSR_READ_INDEX];
         TABLE_FULL <= &tbl_valid_reg;
      end
   end
endmodule : csp_search
`default_nettype wire

/* dv/csp_search_checker.sv */
// Port-level assertions for the search pipeline
`timescale 1ns/100ps
`default_nettype none
module csp_search_checker (
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   // Command and configuration
   input  wire logic        COMMAND_VALID,
   input  wire logic [10:0] COMMAND_BUS,
   input  wire logic [1:0]  TABLE_SIZE_CODE,
   input  wire logic [2:0]  FLAG_DELAY_CODE,
   input  wire logic        SRAM_DEFAULT_DRIVER,
   input  wire logic        FLAG_DEFAULT_DRIVER,
   // Hit lines
   input  wire logic [6:0]  LOCAL_HIT_IN,
   input  wire logic [2:0]  BLOCK_HIT_IN,
   input  wire logic [1:0]  LOCAL_HIT_OUT,
   input  wire logic [2:0]  BLOCK_HIT_OUT,
   // Results
   input  wire logic [23:0] SRAM_ADDRESS_OUT,
   input  wire logic        SRAM_OE_N,
   input  wire logic        SRAM_CHIP_ENABLE_N,
   input  wire logic        SRAM_LATCH_ENABLE_N,
   input  wire logic        SEARCH_SUCCESS_FLAG,
   input  wire logic        SEARCH_RESULT_VALID,
   input  wire logic        FLAG_OE_N
);
   logic       a_reg, a_next, cmd_b;
   logic [6:0] oe_reg, oe_next, ce_reg, ce_next;
   logic [7:0] oe_w, ce_w;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // Cycle B tracking and drive history
   always_comb begin
      cmd_b   = a_reg && COMMAND_VALID && COMMAND_BUS[1:0] == 2'h2;
      a_next  = RST_B && !a_reg && COMMAND_VALID &&
                COMMAND_BUS[1:0] == 2'h2 && !COMMAND_BUS[2];
      oe_w    = {oe_reg, !SRAM_OE_N};
      ce_w    = {ce_reg, !SRAM_CHIP_ENABLE_N};
      oe_next = RST_B ? oe_w[6:0] : 7'h00;
      ce_next = RST_B ? ce_w[6:0] : 7'h00;
   end
   always_ff @(posedge CORE_CLK) begin
      a_reg  <= a_next;
      oe_reg <= oe_next;
      ce_reg <= ce_next;
   end
   local_same_a: assert property (LOCAL_HIT_OUT inside {2'h0, 2'h3})
      else $error("local hit bits differ");
   block_same_a: assert property (BLOCK_HIT_OUT inside {3'h0, 3'h7})
      else $error("block hit bits differ");
   even_addr_a: assert property (!SRAM_CHIP_ENABLE_N |-> !SRAM_ADDRESS_OUT[0])
      else $error("odd hit address");
   quiet_sram_a: assert property (SRAM_OE_N |-> SRAM_CHIP_ENABLE_N && SRAM_LATCH_ENABLE_N)
      else $error("strobe while bus floated");
   quiet_flag_a: assert property (FLAG_OE_N |-> !SEARCH_SUCCESS_FLAG && !SEARCH_RESULT_VALID)
      else $error("flag while floated");
   single_lat_a: assert property (cmd_b && TABLE_SIZE_CODE == 2'h0 ##4 LOCAL_HIT_OUT[0] && LOCAL_HIT_IN == 7'h0
      |-> !SRAM_CHIP_ENABLE_N && !SRAM_LATCH_ENABLE_N) else $error("single latency wrong");
   block_win_a: assert property (cmd_b && TABLE_SIZE_CODE == 2'h1 ##4 LOCAL_HIT_OUT[0] && LOCAL_HIT_IN == 7'h0
      |=> BLOCK_HIT_OUT == 3'h7 && !SRAM_CHIP_ENABLE_N)
      else $error("block latency wrong");
   cascade_win_a: assert property (cmd_b && TABLE_SIZE_CODE[1] ##4 LOCAL_HIT_OUT[0] && LOCAL_HIT_IN == 7'h0
      ##1 BLOCK_HIT_IN == 3'h0 |-> ##1 !SRAM_CHIP_ENABLE_N) else $error("cascade latency wrong");
   loser_quiet_a: assert property (cmd_b && TABLE_SIZE_CODE != 2'h0 ##4 LOCAL_HIT_IN != 7'h0
      |=> BLOCK_HIT_OUT == 3'h0 && SRAM_CHIP_ENABLE_N ##1 SRAM_CHIP_ENABLE_N)
      else $error("loser drove result");
   flag_delay_a: assert property (SRAM_DEFAULT_DRIVER == FLAG_DEFAULT_DRIVER
      |-> !FLAG_OE_N == oe_w[FLAG_DELAY_CODE]) else $error("flag delay wrong");
   flag_hit_a: assert property (SRAM_DEFAULT_DRIVER == FLAG_DEFAULT_DRIVER
      |-> SEARCH_SUCCESS_FLAG == ce_w[FLAG_DELAY_CODE]) else $error("success flag wrong");
endmodule : csp_search_checker
bind csp_search csp_search_checker csp_search_checker_inst (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B), .COMMAND_VALID(COMMAND_VALID),
   .COMMAND_BUS(COMMAND_BUS), .TABLE_SIZE_CODE(TABLE_SIZE_CODE),
   .FLAG_DELAY_CODE(FLAG_DELAY_CODE), .SRAM_DEFAULT_DRIVER(SRAM_DEFAULT_DRIVER),
   .FLAG_DEFAULT_DRIVER(FLAG_DEFAULT_DRIVER), .LOCAL_HIT_IN(LOCAL_HIT_IN),
   .BLOCK_HIT_IN(BLOCK_HIT_IN), .LOCAL_HIT_OUT(LOCAL_HIT_OUT),
   .BLOCK_HIT_OUT(BLOCK_HIT_OUT), .SRAM_ADDRESS_OUT(SRAM_ADDRESS_OUT),
   .SRAM_OE_N(SRAM_OE_N), .SRAM_CHIP_ENABLE_N(SRAM_CHIP_ENABLE_N),
   .SRAM_LATCH_ENABLE_N(SRAM_LATCH_ENABLE_N),
   .SEARCH_SUCCESS_FLAG(SEARCH_SUCCESS_FLAG),
   .SEARCH_RESULT_VALID(SEARCH_RESULT_VALID), .FLAG_OE_N(FLAG_OE_N));
`default_nettype wire

/* dv/csp_host_model.sv */
// Host issuing two-cycle search commands
`timescale 1ns/100ps
`default_nettype none
module csp_host_model (
   // Clock
   input  wire logic        clk,
   // Command and compare buses
   output var  logic        cmd_valid,
   output var  logic [10:0] cmd_bus,
   output var  logic [71:0] dq_bus
);
   initial begin
      cmd_valid = 1'b0;
      cmd_bus   = 11'h000;
      dq_bus    = 72'h0;
   end
   task automatic search(input logic [3:0] gm, input logic [2:0] tag,
      input logic [3:0] cp, input logic [2:0] success_result_reg, input logic [71:0] hi,
      input logic [71:0] lo, input logic drop);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_bus   <= {gm[3], 1'b0, tag, gm[2:0], 1'b0, 2'h2};
      dq_bus    <= hi;
      @(posedge clk);
      cmd_valid <= !drop;
      cmd_bus   <= {2'h0, success_result_reg, cp, 2'h2};
      dq_bus    <= lo;
   endtask : search
   // Released buses show a changed pattern, not the last value
   task automatic release_bus;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_bus   <= ~cmd_bus;
      dq_bus    <= ~dq_bus;
   endtask : release_bus
endmodule : csp_host_model
`default_nettype wire

/* dv/tb_csp_search.sv */
// Self-checking bench for the search pipeline
`timescale 1ns/100ps
`default_nettype none
module tb_csp_search;
   localparam logic [71:0] ONES = {72{1'b1}};
   localparam logic [71:0] H1 = {9{8'ha5}}, L1 = {9{8'h3c}};
   localparam logic [71:0] H2 = {9{8'h5a}}, L2 = {9{8'hc3}};
   logic        clk, rst_b, cv, sdd, fdd, fnf, tw_en, gw_en, st_op, drop_b;
   logic        oe_n, ce_n, ale_n, we_n, ssf_o, ssv_o, foe_n, full_o, sbe;
   logic [1:0]  tsz, lho_o;
   logic [2:0]  fd, block_hit_in, bho_o, st_pair, ssr_i;
   logic [3:0]  st_cmp, cp_sel;
   logic [4:0]  wi;
   logic [6:0]  local_hit_in;
   logic [10:0] cb;
   logic [23:0] adr_o;
   logic [24:0] ssr_d;
   logic [71:0] dq, tw_d, tw_m;
   int          bad_count, n_checks;
   csp_host_model csp_host_model_inst (.clk(clk), .cmd_valid(cv), .cmd_bus(cb),
      .dq_bus(dq));
   csp_search csp_search_inst (.CORE_CLK(clk), .RST_B(rst_b),
      .COMMAND_VALID(cv), .COMMAND_BUS(cb), .COMPARE_DATA_BUS(dq),
      .TABLE_SIZE_CODE(tsz), .FLAG_DELAY_CODE(fd), .SRAM_DEFAULT_DRIVER(sdd),
      .FLAG_DEFAULT_DRIVER(fdd), .FIRST_NONFULL_DEVICE(fnf),
      .STORE_BLOCK_ENABLE(sbe), .TABLE_WR_EN(tw_en), .TABLE_WR_LOC(wi[3:0]),
      .TABLE_WR_DATA(tw_d), .TABLE_WR_MASK(tw_m), .GMASK_WR_EN(gw_en),
      .GMASK_WR_INDEX(wi), .GMASK_WR_DATA(tw_d), .STORE_OP(st_op),
      .STORE_CMP_INDEX(st_cmp), .STORE_PAIR(st_pair), .SSR_READ_INDEX(ssr_i),
      .LOCAL_HIT_IN(local_hit_in), .BLOCK_HIT_IN(block_hit_in), .LOCAL_HIT_OUT(lho_o),
      .BLOCK_HIT_OUT(bho_o), .SRAM_ADDRESS_OUT(adr_o), .SRAM_OE_N(oe_n),
      .SRAM_CHIP_ENABLE_N(ce_n), .SRAM_LATCH_ENABLE_N(ale_n),
      .SRAM_WRITE_ENABLE_N(we_n), .SEARCH_SUCCESS_FLAG(ssf_o),
      .SEARCH_RESULT_VALID(ssv_o), .FLAG_OE_N(foe_n), .SSR_READ_DATA(ssr_d),
      .TABLE_FULL(full_o));
   always #10 clk = ~clk;
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [23:0] mk(input logic [2:0] t, input logic [3:0] l);
      return {t, 17'h0, l};
   endfunction : mk
   task automatic cfg(input logic [1:0] t, input logic [2:0] d, input logic dd);
      @(posedge clk);
      tsz <= t;
      fd  <= d;
      sdd <= dd;
      fdd <= dd;
      repeat (8) @(posedge clk);
   endtask : cfg
   task automatic wr(input logic g, input logic [4:0] i, input logic [71:0] d,
      input logic [71:0] m);
      @(posedge clk);
      tw_en <= !g;
      gw_en <= g;
      wi    <= i;
      tw_d  <= d;
      tw_m  <= m;
      @(posedge clk);
      tw_en <= 1'b0;
      gw_en <= 1'b0;
   endtask : wr
   task automatic do_search(input logic [3:0] gm, input logic [2:0] tag,
      input logic [2:0] success_result_reg, input logic [71:0] hi, input logic [71:0] lo,
      input logic own, input logic drv, input logic win, input logic [23:0] ea);
      int          t_oe = 0, t_fl = 0;
      int          lat = (tsz == 2'h0) ? 4 : (tsz == 2'h1) ? 5 : 6;
      logic [1:0]  local_hit_out = 2'h0, ctl = 2'h0, flg = 2'h0;
      logic [2:0]  block_hit_out = 3'h0;
      logic [23:0] got = 24'h0;
      csp_host_model_inst.search(gm, tag, cp_sel, success_result_reg, hi, lo, drop_b);
      csp_host_model_inst.release_bus;
      for (int n = 1; n <= lat + fd + 2; n++) begin
         @(posedge clk);
         #1;
         local_hit_out = local_hit_out | lho_o;
         block_hit_out = block_hit_out | bho_o;
         if (!oe_n && t_oe == 0) begin
            t_oe = n;
            got  = adr_o;
            ctl  = {ce_n, ale_n};
         end
         if (!foe_n && t_fl == 0) begin
            t_fl = n;
            flg  = {ssf_o, ssv_o};
         end
      end
      check("drive cycle", 32'(t_oe), drv ? 32'(lat - 1) : 32'h0);
      check("flag cycle", 32'(t_fl), drv ? 32'(lat + fd - 1) : 32'h0);
      check("local hit", 32'(local_hit_out), own ? 32'h3 : 32'h0);
      if (tsz != 2'h0) check("block hit", 32'(block_hit_out), 32'(own && local_hit_in == 7'h0 ? 3'h7 : 3'h0));
      if (drv && t_oe == 0) wrap_up;
      if (drv) begin
         check("address", 32'(got), 32'(ea));
         check("strobes", 32'(ctl), win ? 32'h0 : 32'h3);
         check("flags", 32'(flg), 32'({win, 1'b1}));
         @(posedge clk);
         ssr_i <= success_result_reg;
         repeat (2) @(posedge clk);
         #1;
         check("result reg", 32'(ssr_d), 32'({win, ea}));
      end
   endtask : do_search
   task automatic s_single;
      check("reset", 32'({oe_n, ce_n, ale_n, we_n, foe_n, ssf_o, ssv_o}), 32'h7c);
      cfg(2'h0, 3'h1, 1'b1);
      wr(0, 0, H1 ^ 72'h1, ONES);
      wr(0, 1, L1 ^ 72'h2, ONES);
      wr(0, 4, H1, ONES);
      wr(0, 5, L1, ONES);
      wr(0, 6, H1 ^ 72'h4, ~72'h4);
      wr(0, 7, L1, ONES);
      wr(1, 0, ONES, ONES);
      wr(1, 1, ONES, ONES);
      wr(1, 2, ~72'h1, ONES);
      wr(1, 3, ~72'h1, ONES);
      wr(1, 4, ~72'h2, ONES);
      wr(1, 5, ~72'h1, ONES);
      do_search(0, 5, 2, H1, L1, 1, 1, 1, mk(5, 4));
      do_search(1, 1, 3, H1, L1 ^ 72'h2, 1, 1, 1, mk(1, 0));
      do_search(0, 0, 4, H1 ^ 72'h4, L1, 1, 1, 1, mk(0, 6));
      do_search(2, 7, 5, H1 ^ 72'h2, L1 ^ 72'h2, 0, 1, 0, 24'h0);
   endtask : s_single
   task automatic s_b2b;
      logic [23:0] seen [8];
      csp_host_model_inst.search(0, 5, 0, 0, H1, L1, 1'b0);
      csp_host_model_inst.search(1, 1, 0, 1, H1 ^ 72'h1, L1 ^ 72'h2, 1'b0);
      csp_host_model_inst.release_bus;
      for (int n = 1; n <= 7; n++) begin
         @(posedge clk);
         #1;
         seen[n] = oe_n ? 24'hffffff : adr_o;
      end
      check("first", 32'(seen[1]), 32'(mk(5, 4)));
      check("gap", 32'(seen[2]), 32'hffffff);
      check("second", 32'(seen[3]), 32'(mk(1, 0)));
      repeat (6) @(posedge clk);
   endtask : s_b2b
   task automatic s_store(input logic [3:0] c, input logic [2:0] p,
      input logic nf, input logic be);
      cp_sel = c;
      do_search(0, 0, 6, H2 ^ {68'h0, c}, L2, 0, 1, 0, 24'h0);
      @(posedge clk);
      st_op   <= 1'b1;
      st_cmp  <= c;
      st_pair <= p;
      fnf     <= nf;
      sbe     <= be;
      @(posedge clk);
      st_op   <= 1'b0;
      fnf     <= 1'b1;
      sbe     <= 1'b1;
      do_search(0, 2, 6, H2 ^ {68'h0, c}, L2, nf & be, 1, nf & be,
         nf & be ? mk(2, {p, 1'b0}) : 24'h0);
      check("full", 32'(full_o), 32'h0);
      cp_sel = 4'h0;
   endtask : s_store
   task automatic s_cascade;
      cfg(2'h1, 3'h0, 1'b0);
      do_search(0, 3, 1, H1, L1, 1, 1, 1, mk(3, 4));
      local_hit_in <= 7'h10;
      do_search(0, 3, 1, H1, L1, 1, 0, 0, 24'h0);
      local_hit_in <= 7'h00;
      cfg(2'h2, 3'h7, 1'b1);
      do_search(0, 6, 0, H1, L1, 1, 1, 1, mk(6, 4));
      block_hit_in <= 3'h2;
      do_search(0, 6, 0, H1, L1, 1, 0, 0, 24'h0);
      block_hit_in    <= 3'h0;
      drop_b = 1'b1;
      do_search(0, 6, 0, H1, L1, 0, 0, 0, 24'h0);
      drop_b = 1'b0;
   endtask : s_cascade
   initial begin
      {clk, rst_b, sdd, fdd, tw_en, gw_en, st_op, drop_b} = 8'h00;
      {tsz, fd, block_hit_in, st_pair, ssr_i, st_cmp, cp_sel, wi, local_hit_in} = 31'h0;
      {tw_d, tw_m} = 144'h0;
      {fnf, sbe} = 2'h3;
      bad_count = 0;
      n_checks = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      s_single;
      s_b2b;
      s_store(4'h7, 3'h5, 1'b1, 1'b1);
      s_store(4'h9, 3'h6, 1'b0, 1'b1);
      s_store(4'ha, 3'h7, 1'b1, 1'b0);
      s_cascade;
      wrap_up;
   end
endmodule : tb_csp_search
`default_nettype wire
